// *** prog_stack_pkg.sv ***
package prog_stack_pkg;
    localparam int WORD_W = 4;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
    localparam logic [PTR_W-1:0] PTR_FULL = 4'hF;
    localparam logic [PTR_W-1:0] PTR_EMPTY = 4'h0;
    localparam logic [PTR_W-1:0] PTR_STEP = 4'h1;
    localparam logic [WORD_W-1:0] WORD_ZERO = 4'h0;
    localparam logic [WORD_W-1:0] WORD_ONES = 4'hF;
    localparam logic [WORD_W-1:0] WORD_ONE = 4'h1;

    typedef enum logic [1:0]
    {
        OP_RETURN = 2'h0,
        OP_BRANCH = 2'h1,
        OP_CALL = 2'h2,
        OP_FETCH = 2'h3
    } stack_op_t;
endpackage

// *** program_counter_stack.sv ***
`timescale 1ns/1ns
module program_counter_stack
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Sequencer pins
    input wire logic stack_clk_in,
    input wire logic exec_strobe_n_in,
    input wire logic [1:0] instr_sel_in,
    input wire logic [prog_stack_pkg::WORD_W-1:0] data_in_n_in,
    input wire logic carry_in_n_in,
    input wire logic stack_clear_n_in,
    input wire logic obus_enable_n_in,
    // Counter output bus
    output logic [prog_stack_pkg::WORD_W-1:0] pc_out_n_out,
    output logic pc_out_oe_out,
    // Fetch address bus
    output logic [prog_stack_pkg::WORD_W-1:0] fetch_addr_out,
    output logic fetch_addr_oe_out,
    // Status
    output logic carry_out_n_out,
    output logic full_flag_n_out,
    output logic empty_flag_n_out
);
    import prog_stack_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Every sequencer pin is asynchronous to mclk; two stages before use.
    localparam int SYNC_W = 7 + WORD_W;
    // Reset to idle pin levels: zeros would fake a strobe and a clear
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'h1, 1'h1, 2'h0, WORD_ZERO,
                                               1'h1, 1'h1, 1'h1};
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic cp_prev;

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end
        else
        begin
            sync1 <= {stack_clk_in, exec_strobe_n_in, instr_sel_in,
                      data_in_n_in, carry_in_n_in, stack_clear_n_in,
                      obus_enable_n_in};
            sync2 <= sync1;
        end
    end

    logic cp;
    logic ex_n;
    logic [1:0] sel;
    logic [WORD_W-1:0] din_n;
    logic ci_n;
    logic clr_n;
    logic oen_n;

    assign {cp, ex_n, sel, din_n, ci_n, clr_n, oen_n} = sync2;

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            cp_prev <= 1'b1;
        else
            cp_prev <= cp;
    end

    logic cp_rise;
    assign cp_rise = cp && !cp_prev;

    // ****************************************
    // Instruction capture
    // ****************************************
    stack_op_t op;

    // Code is set up while the clock is high, then held for the low phase
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            op <= OP_FETCH;
        else if (cp)
            op <= stack_op_t'(sel);
    end

    // ****************************************
    // Storage, pointer and latch
    // ****************************************
    logic [WORD_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] stack_ptr;
    logic [WORD_W-1:0] out_latch;
    logic pend;
    logic active;
    logic [PTR_W-1:0] work_addr;
    logic [WORD_W-1:0] inc_word;
    logic [WORD_W-1:0] wdata;
    logic wr_en;

    // Execution only while both clock and strobe are low
    assign active = !cp && !ex_n;

    assign inc_word = ci_n ? out_latch : out_latch + WORD_ONE;

    always_comb
    begin
        work_addr = stack_ptr;
        wdata = ~din_n;
        wr_en = 1'b0;
        unique case (op)
            OP_RETURN:
                wr_en = 1'b0;
            OP_BRANCH:
                wr_en = active;
            OP_CALL:
            begin
                work_addr = stack_ptr + PTR_STEP;
                wr_en = active;
            end
            OP_FETCH:
            begin
                wdata = inc_word;
                wr_en = active;
            end
        endcase
    end

    // Write of latch+1 is idempotent because the latch holds while low
    always_ff @(posedge mclk_in)
    begin
        if (!clr_n)
            mem[PTR_EMPTY] <= WORD_ZERO;
        else if (wr_en)
            mem[work_addr] <= wdata;
    end

    // Pointer moves are armed in the low phase, taken at the rise
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in || !clr_n)
            pend <= 1'b0;
        else if (cp_rise)
            pend <= 1'b0;
        else if (active && (op == OP_CALL || op == OP_RETURN))
            pend <= 1'b1;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in || !clr_n)
            stack_ptr <= PTR_RESET;
        else if (cp_rise && pend)
        begin
            if (op == OP_CALL)
                stack_ptr <= stack_ptr + PTR_STEP;
            else
                stack_ptr <= stack_ptr - PTR_STEP;
        end
    end

    // Latch follows storage while high, holds while low
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            out_latch <= WORD_ZERO;
        else if (cp && !cp_rise)
            out_latch <= mem[stack_ptr];
    end

    // ****************************************
    // Output drivers
    // ****************************************
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            pc_out_n_out <= WORD_ONES;
            pc_out_oe_out <= 1'b0;
        end
        else
        begin
            pc_out_n_out <= ~out_latch;
            pc_out_oe_out <= !oen_n;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            fetch_addr_out <= WORD_ZERO;
            fetch_addr_oe_out <= 1'b0;
        end
        else
        begin
            fetch_addr_out <= out_latch;
            fetch_addr_oe_out <= active && op == OP_FETCH;
        end
    end

    // ****************************************
    // Status
    // ****************************************
    // Flags lag the pointer by one mclk; fine against the slow pin clock
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            full_flag_n_out <= 1'b1;
            empty_flag_n_out <= 1'b0;
            carry_out_n_out <= 1'b1;
        end
        else
        begin
            full_flag_n_out <= !(stack_ptr == PTR_FULL);
            empty_flag_n_out <= !(stack_ptr == PTR_EMPTY);
            carry_out_n_out <= !(out_latch == WORD_ONES && !ci_n);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_full_flag;
        @(posedge mclk_in) disable iff (sys_rst_in)
        1'b1 |=> full_flag_n_out == ($past(stack_ptr) != PTR_FULL);
    endproperty
    a_full_flag: assert property (p_full_flag)
        else $error("full flag does not match pointer");

    property p_empty_flag;
        @(posedge mclk_in) disable iff (sys_rst_in)
        1'b1 |=> empty_flag_n_out == ($past(stack_ptr) != PTR_EMPTY);
    endproperty
    a_empty_flag: assert property (p_empty_flag)
        else $error("empty flag does not match pointer");

    property p_fetch_drive;
        @(posedge mclk_in) disable iff (sys_rst_in)
        fetch_addr_oe_out |-> $past(!cp && !ex_n && op == OP_FETCH);
    endproperty
    a_fetch_drive: assert property (p_fetch_drive)
        else $error("fetch bus driven outside fetch low phase");

    property p_obus_enable;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !oen_n |=> pc_out_oe_out;
    endproperty
    a_obus_enable: assert property (p_obus_enable)
        else $error("counter bus not driven while enabled");

    property p_ptr_idle;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clr_n && !pend) |=> $stable(stack_ptr);
    endproperty
    a_ptr_idle: assert property (p_ptr_idle)
        else $error("pointer moved with no armed operation");

    property p_call_push;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clr_n && cp_rise && pend && op == OP_CALL) |=>
            stack_ptr == $past(stack_ptr) + PTR_STEP;
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call did not increment pointer");

    property p_latch_hold;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (!cp && $past(!cp)) |-> $stable(out_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("output latch moved in low phase");

    property p_clear;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !clr_n |=> stack_ptr == PTR_RESET ##1 !empty_flag_n_out;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not empty the stack");

    property p_carry;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (out_latch == WORD_ONES && !ci_n) |=> !carry_out_n_out;
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry out not asserted at all ones");

    property p_return_pop;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clr_n && cp_rise && pend && op == OP_RETURN) |=>
            stack_ptr == $past(stack_ptr) - PTR_STEP;
    endproperty
    a_return_pop: assert property (p_return_pop)
        else $error("return did not decrement pointer");

    property p_obus_off;
        @(posedge mclk_in) disable iff (sys_rst_in)
        oen_n |=> !pc_out_oe_out;
    endproperty
    a_obus_off: assert property (p_obus_off)
        else $error("counter bus driven while disabled");

    property p_fetch_float;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (cp || ex_n) |=> !fetch_addr_oe_out;
    endproperty
    a_fetch_float: assert property (p_fetch_float)
        else $error("fetch bus driven with clock or strobe high");

    property p_branch_write;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clr_n && active && op == OP_BRANCH) |=>
            mem[stack_ptr] == ~$past(din_n);
    endproperty
    a_branch_write: assert property (p_branch_write)
        else $error("branch did not load current entry");

    property p_call_write;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clr_n && active && op == OP_CALL) |=>
            mem[stack_ptr + PTR_STEP] == ~$past(din_n);
    endproperty
    a_call_write: assert property (p_call_write)
        else $error("call did not load the next entry");

    property p_fetch_inc;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clr_n && active && op == OP_FETCH && !ci_n) |=>
            mem[stack_ptr] == $past(out_latch) + WORD_ONE;
    endproperty
    a_fetch_inc: assert property (p_fetch_inc)
        else $error("fetch did not increment counter");

    property p_fetch_keep;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (clr_n && active && op == OP_FETCH && ci_n) |=>
            mem[stack_ptr] == $past(out_latch);
    endproperty
    a_fetch_keep: assert property (p_fetch_keep)
        else $error("iterative fetch changed counter");

    property p_latch_follow;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (cp && $past(cp)) |=> out_latch == $past(mem[stack_ptr]);
    endproperty
    a_latch_follow: assert property (p_latch_follow)
        else $error("output latch not following storage");

    property p_carry_off;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !(out_latch == WORD_ONES && !ci_n) |=> carry_out_n_out;
    endproperty
    a_carry_off: assert property (p_carry_off)
        else $error("carry out asserted below all ones");
endmodule

// *** seq_model.sv ***
`timescale 1ns/1ns
module seq_model
(
    // Clock
    input wire logic mclk_in,
    // Sequencer pins
    output logic stack_clk_out,
    output logic exec_strobe_n_out,
    output logic [1:0] instr_sel_out,
    output logic [3:0] data_in_n_out,
    output logic carry_in_n_out,
    // Fetch bus
    input wire logic [3:0] fetch_addr_in,
    input wire logic fetch_addr_oe_in
);
    // ****
    // Pins
    // ****
    // Stack clock idles high between ops
    initial
    begin
        stack_clk_out = 1'b1;
        exec_strobe_n_out = 1'b1;
        instr_sel_out = 2'h0;
        data_in_n_out = 4'h0;
        carry_in_n_out = 1'b1;
    end
    // Eight mclk a phase, well over the two the sync needs
    task automatic run_op(input logic [1:0] op, input logic [3:0] d,
        input logic ci, input logic s, output logic [3:0] xa,
        output logic xo);
        @(negedge mclk_in);
        instr_sel_out = op;
        exec_strobe_n_out = s;
        data_in_n_out = d;
        carry_in_n_out = ci;
        repeat (8) @(negedge mclk_in);
        stack_clk_out = 1'b0;
        repeat (6) @(negedge mclk_in);
        xa = fetch_addr_in;
        xo = fetch_addr_oe_in;
        repeat (2) @(negedge mclk_in);
        stack_clk_out = 1'b1;
        repeat (8) @(negedge mclk_in);
        // Released data shows the inverse, not a stale copy
        data_in_n_out = ~d;
        exec_strobe_n_out = 1'b1;
    endtask
endmodule

// *** program_counter_stack_test.sv ***
`timescale 1ns/1ns
module program_counter_stack_test;
    import prog_stack_pkg::*;
    // ****
    // Bench
    // ****
    typedef struct
    {
        stack_op_t op;
        logic [3:0] d;
        logic ci;
        logic [3:0] exp;
    } row_t;
    logic mclk, rst, sclk, strb_n, ci_n, clr_n, oe_n;
    logic pc_oe, x_oe, co_n, full_n, empty_n;
    logic [1:0] sel;
    logic [3:0] din_n, pc_n, x_addr, ptr;
    logic [3:0] mem [DEPTH];
    int failures, checks;
    row_t rows [10] = '{'{OP_BRANCH, 4'hA, 1'b1, 4'h5},
        '{OP_FETCH, 4'h0, 1'b0, 4'h6}, '{OP_FETCH, 4'h0, 1'b1, 4'h6},
        '{OP_CALL, 4'h3, 1'b1, 4'hC}, '{OP_FETCH, 4'h0, 1'b0, 4'hD},
        '{OP_CALL, 4'hF, 1'b1, 4'h0}, '{OP_RETURN, 4'h0, 1'b1, 4'hD},
        '{OP_BRANCH, 4'h0, 1'b0, 4'hF}, '{OP_FETCH, 4'h0, 1'b0, 4'h0},
        '{OP_RETURN, 4'h0, 1'b1, 4'h6}};
    program_counter_stack u_program_counter_stack(.mclk_in(mclk),
        .sys_rst_in(rst), .stack_clk_in(sclk), .exec_strobe_n_in(strb_n),
        .instr_sel_in(sel), .data_in_n_in(din_n), .carry_in_n_in(ci_n),
        .stack_clear_n_in(clr_n), .obus_enable_n_in(oe_n),
        .pc_out_n_out(pc_n), .pc_out_oe_out(pc_oe), .fetch_addr_out(x_addr),
        .fetch_addr_oe_out(x_oe), .carry_out_n_out(co_n),
        .full_flag_n_out(full_n), .empty_flag_n_out(empty_n));
    seq_model u_seq_model(.mclk_in(mclk), .stack_clk_out(sclk),
        .exec_strobe_n_out(strb_n), .instr_sel_out(sel),
        .data_in_n_out(din_n), .carry_in_n_out(ci_n),
        .fetch_addr_in(x_addr), .fetch_addr_oe_in(x_oe));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task check(input string nm, input logic [3:0] seen, input logic [3:0] e);
        checks++;
        if (seen !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task verify(input logic ci);
        check("pc_n", pc_n, ~mem[ptr]);
        check("pc_oe", {3'h0, pc_oe}, {3'h0, ~oe_n});
        check("full_n", {3'h0, full_n}, {3'h0, ptr != 4'hF});
        check("empty_n", {3'h0, empty_n}, {3'h0, ptr != 4'h0});
        check("co_n", {3'h0, co_n}, {3'h0, ~(mem[ptr] == 4'hF && !ci)});
    endtask
    task do_op(input stack_op_t op, input logic [3:0] d, input logic ci,
        input logic s);
        logic [3:0] xa;
        logic xo;
        logic [3:0] old;
        logic [3:0] mid;
        old = mem[ptr];
        fork
            u_seq_model.run_op(op, d, ci, s, xa, xo);
            begin
                // Sampled with the fetch bus, deep in the low phase
                repeat (15) @(negedge mclk);
                mid = pc_n;
            end
        join
        check("pc_low", mid, ~old);
        if (!s)
        begin
            case (op)
                OP_RETURN: ptr = ptr - 4'h1;
                OP_BRANCH: mem[ptr] = ~d;
                OP_CALL:
                begin
                    ptr = ptr + 4'h1;
                    mem[ptr] = ~d;
                end
                default: mem[ptr] = old + {3'h0, ~ci};
            endcase
        end
        check("x_oe", {3'h0, xo}, {3'h0, op == OP_FETCH && !s});
        if (op == OP_FETCH && !s)
            check("x_addr", xa, old);
        verify(ci);
    endtask
    // Clear zeroes entry 0 and the pointer
    task clear;
        clr_n = 1'b0;
        repeat (4) @(negedge mclk);
        clr_n = 1'b1;
        repeat (8) @(negedge mclk);
        ptr = 4'h0;
        mem[0] = 4'h0;
        verify(1'b1);
    endtask
    task reset_values;
        check("rst_pc", pc_n, 4'hF);
        check("rst_pc_oe", {3'h0, pc_oe}, 4'h0);
        check("rst_x_addr", x_addr, 4'h0);
        check("rst_x_oe", {3'h0, x_oe}, 4'h0);
        check("rst_co", {3'h0, co_n}, 4'h1);
        check("rst_full", {3'h0, full_n}, 4'h1);
        check("rst_empty", {3'h0, empty_n}, 4'h0);
    endtask
    task conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
    initial
    begin
        rst = 1'b1;
        clr_n = 1'b1;
        oe_n = 1'b0;
        failures = 0;
        checks = 0;
        repeat (3) @(negedge mclk);
        reset_values();
        rst = 1'b0;
        clear();
        foreach (rows[i])
        begin
            do_op(rows[i].op, rows[i].d, rows[i].ci, 1'b0);
            check("row_pc", ~pc_n, rows[i].exp);
        end
        do_op(OP_CALL, 4'h1, 1'b1, 1'b1);
        oe_n = 1'b1;
        repeat (4) @(negedge mclk);
        check("pc_oe_off", {3'h0, pc_oe}, 4'h0);
        oe_n = 1'b0;
        repeat (4) @(negedge mclk);
        // Fifteen pushes fill the stack and the sixteenth one wraps
        for (int i = 0; i < 16; i++)
            do_op(OP_CALL, 4'(i), 1'b1, 1'b0);
        do_op(OP_RETURN, 4'h0, 1'b1, 1'b0);
        // Reset in mid-run: pointer returns to 0, storage is kept
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        reset_values();
        rst = 1'b0;
        repeat (8) @(negedge mclk);
        ptr = 4'h0;
        verify(1'b1);
        clear();
        conclude();
    end
endmodule
